// >>> pgo_dev.sv
// camera end: gain/offset on sensor pixels, line valid delay, 8-tap channel mapping
// config and line trigger live on clk_sys; pixel path runs on the link clock
// assumes sensor_px is produced on the link clock, answering sensor_rd in the same cycle
module pgo_dev
  import pgo_pkg::*;
#(
  parameter int NUM_TAPS = TAPS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire logic                      cfg_we,
  input  wire logic [13:0]               cfg_gain_raw,
  input  wire logic signed [4:0]         cfg_gain_db,
  input  wire logic                      cfg_gain_by_db,
  input  wire logic signed [12:0]        cfg_off_raw,
  input  wire logic signed [12:0]        cfg_off_dn,
  input  wire logic                      cfg_off_by_dn,
  input  wire logic [1:0]                cfg_depth,
  input  wire logic [1:0]                cfg_exp_mode,
  input  wire logic                      cfg_single_line,
  input  wire logic                      cfg_fast_clk,
  input  wire logic                      cfg_binning,
  input  wire logic                      cfg_sensor_4k,
  input  wire logic                      cfg_roi_en,
  input  wire logic [12:0]               cfg_roi_len,
  input  wire logic [15:0]               cfg_exp_cyc,
  input  wire logic                      line_start,
  output logic                           cfg_busy,
  output logic                           sensor_rd,
  input  wire logic [TAPS-1:0][PX_W-1:0] sensor_px,
  pgo_if.dev                             link
);

  if (NUM_TAPS != TAPS) begin : g_chk
    $error("pgo_dev serves exactly eight taps");
  end

  typedef struct packed {
    pgo_cfg_s   shadow;
    logic       req_tg;
    logic [1:0] ack_s;
    logic       ls_tg;
  } pgo_sys_s;

  typedef struct packed {
    logic [1:0]                  rst_s;
    logic [2:0]                  req_s;
    logic [2:0]                  ls_s;
    logic                        ack_tg;
    pgo_cfg_s                    cfg;
    pgo_state_e                  state;
    logic [DLY_W-1:0]            dly;
    logic [BEAT_W-1:0]           beat;
    logic [NUM_TX-1:0][CH_W-1:0] tx;
  } pgo_lnk_s;

  pgo_sys_s s_r, s_nxt;
  pgo_lnk_s l_r, l_nxt;

  logic pclk;
  assign pclk = link.serializer_clock_input;

  // ---------------- helpers ----------------
  function automatic logic [13:0] clamp_gain(input logic [13:0] g, input logic [1:0] d);
    logic [13:0] gmax;
    gmax = (d == DEPTH_8) ? GAIN_MAX8 : (d == DEPTH_10) ? GAIN_MAX10 : GAIN_MAX12;
    if (g < GAIN_MIN) return GAIN_MIN;
    if (g > gmax) return gmax;
    return g;
  endfunction : clamp_gain

  function automatic logic signed [12:0] dn_to_raw(input logic signed [12:0] dn,
                                                   input logic [1:0] d);
    logic signed [17:0] w;
    w = {{5{dn[12]}}, dn};
    // one output count equals 16, 4 or 1 integer steps by depth
    case (d)
      DEPTH_8:  w = w <<< 4;
      DEPTH_10: w = w <<< 2;
      default:  w = w;
    endcase
    if (w < 18'(OFF_MIN)) return OFF_MIN;
    if (w > 18'(OFF_MAX)) return OFF_MAX;
    return w[12:0];
  endfunction : dn_to_raw

  function automatic logic [11:0] scale_px(input logic [11:0] px, input pgo_cfg_s c);
    logic [25:0]        prod;
    logic signed [15:0] sum;
    logic [11:0]        sat;
    prod = 26'(px) * 26'(c.gain);
    sum  = $signed({2'b00, prod[25:GAIN_FRAC]}) + {{3{c.offset[12]}}, c.offset};
    if (sum < 16'sd0) begin
      sat = '0;
    end else if (sum > $signed({4'h0, PX_FULL})) begin
      sat = PX_FULL;
    end else begin
      sat = sum[11:0];
    end
    // offset added at 12-bit scale, so dropping low bits sets steps per count
    case (c.depth)
      DEPTH_8:  return {4'h0, sat[11:4]};
      DEPTH_10: return {2'h0, sat[11:2]};
      default:  return sat;
    endcase
  endfunction : scale_px

  function automatic logic [DLY_W-1:0] line_delay(input pgo_cfg_s c);
    logic [DLY_W-1:0] base;
    logic [DLY_W-1:0] edge1;
    base  = c.fast_clk ? (c.binning ? DLY_B80B_CYC : DLY_B80_CYC)
                       : (c.binning ? DLY_B40B_CYC : DLY_B40_CYC);
    edge1 = c.fast_clk ? (c.binning ? DLY_E80B_CYC : DLY_E80_CYC)
                       : (c.binning ? DLY_E40B_CYC : DLY_E40_CYC);
    case (c.exp_mode)
      EXP_PROG: return base + DLY_W'(c.exp_cyc);
      EXP_EDGE: return c.single_line ? edge1 : base;
      default:  return base;
    endcase
  endfunction : line_delay

  function automatic logic [BEAT_W-1:0] line_beats(input pgo_cfg_s c);
    logic [12:0] n;
    n = c.sensor_4k ? 13'(N_4K) : 13'(N_2K);
    if (c.binning) n = n >> 1;
    if (c.roi_en) n = c.roi_len;
    return BEAT_W'(n >> 3);
  endfunction : line_beats

  function automatic logic [NUM_TX-1:0][CH_W-1:0] map_taps(
      input logic [TAPS-1:0][LINK_W-1:0] px, input logic lv, input logic dv);
    logic [NUM_TX-1:0][CH_W-1:0] w;
    w = '0;
    for (int t = 0; t < TAPS; t++) begin
      for (int b = 0; b < LINK_W; b++) begin
        w[t / 3][TAP_MAP[t % 3][b]] = px[t][b];
      end
    end
    for (int x = 0; x < NUM_TX; x++) begin
      w[x][LVAL_CH] = lv;
      w[x][DVAL_CH] = dv;
    end
    return w;
  endfunction : map_taps

  // ---------------- clk_sys side ----------------
  logic busy;
  assign busy     = s_r.req_tg != s_r.ack_s[1];
  assign cfg_busy = busy;

  always_comb begin
    pgo_cfg_s c;
    c     = s_r.shadow;
    s_nxt = s_r;
    s_nxt.ack_s = {s_r.ack_s[0], l_r.ack_tg};
    // shadow only changes while the link side is not copying it
    if (cfg_we && !busy) begin
      c.depth       = cfg_depth;
      c.gain        = clamp_gain(cfg_gain_by_db ? pgo_gain_from_db(
                        (cfg_gain_db < DB_MIN) ? DB_MIN :
                        (cfg_gain_db > DB_MAX) ? DB_MAX : cfg_gain_db)
                        : cfg_gain_raw, cfg_depth);
      c.offset      = cfg_off_by_dn ? dn_to_raw(cfg_off_dn, cfg_depth)
                                    : dn_to_raw(cfg_off_raw, DEPTH_12);
      c.exp_mode    = cfg_exp_mode;
      c.single_line = cfg_single_line;
      c.fast_clk    = cfg_fast_clk;
      c.binning     = cfg_binning;
      c.sensor_4k   = cfg_sensor_4k;
      c.roi_en      = cfg_roi_en;
      c.roi_len     = cfg_roi_len;
      c.exp_cyc     = cfg_exp_cyc;
      s_nxt.shadow  = c;
      s_nxt.req_tg  = ~s_r.req_tg;
    end
    if (line_start) begin
      s_nxt.ls_tg = ~s_r.ls_tg;
    end
    if (srst) begin
      s_nxt        = '0;
      s_nxt.shadow = CFG_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  // ---------------- link clock side ----------------
  logic                          lrst;
  logic [TAPS-1:0][LINK_W-1:0]   px_lnk;
  assign lrst      = l_r.rst_s[1];
  assign sensor_rd = l_r.state == ST_LINE;

  for (genvar t = 0; t < TAPS; t++) begin : g_tap
    logic [11:0] scaled;
    assign scaled    = scale_px(sensor_px[t], l_r.cfg);
    assign px_lnk[t] = scaled[LINK_W-1:0];
  end

  always_comb begin
    l_nxt       = l_r;
    l_nxt.rst_s = {l_r.rst_s[0], srst};
    l_nxt.req_s = {l_r.req_s[1:0], s_r.req_tg};
    l_nxt.ls_s  = {l_r.ls_s[1:0], s_r.ls_tg};
    l_nxt.tx    = map_taps('0, 1'b0, 1'b0);
    if (l_r.req_s[2] != l_r.req_s[1]) begin
      l_nxt.cfg    = s_r.shadow;
      l_nxt.ack_tg = ~l_r.ack_tg;
    end
    case (l_r.state)
      ST_IDLE: begin
        // a trigger during a delay or line is dropped
        if (l_r.ls_s[2] != l_r.ls_s[1]) begin
          l_nxt.dly   = line_delay(l_r.cfg);
          l_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        l_nxt.dly = l_r.dly - 1'b1;
        if (l_r.dly <= DLY_W'(1)) begin
          l_nxt.beat  = line_beats(l_r.cfg) - 1'b1;
          l_nxt.state = ST_LINE;
        end
      end
      ST_LINE: begin
        l_nxt.tx   = map_taps(px_lnk, 1'b1, 1'b1);
        l_nxt.beat = l_r.beat - 1'b1;
        if (l_r.beat == '0) begin
          l_nxt.state = ST_IDLE;
        end
      end
      default: l_nxt.state = ST_IDLE;
    endcase
    if (lrst) begin
      l_nxt       = '0;
      // keep shifting, else clearing the synchroniser makes reset pulse one cycle in three while srst is high
      l_nxt.rst_s = {l_r.rst_s[0], srst};
      // toggles restart from zero; the far side is never sampled unsynchronised
      l_nxt.cfg   = CFG_RST;
      l_nxt.state = ST_IDLE;
    end
  end

  always_ff @(posedge pclk) begin
    l_r <= l_nxt;
  end

  assign link.tx_ch = l_r.tx;

endmodule : pgo_dev

// >>> pgo_if.sv
// parallel 8-tap link: three 28-channel transmitter words plus the pixel clock
// assumes the bench drives serializer_clock_input and joins both ends here
interface pgo_if;
  import pgo_pkg::*;
  logic                            serializer_clock_input;
  logic [NUM_TX-1:0][CH_W-1:0]     tx_ch;

  modport dev (input serializer_clock_input, output tx_ch);
  modport rx  (input serializer_clock_input, input tx_ch);
endinterface : pgo_if

// >>> pgo_monitor.sv
// checker for the 8-tap link: flag channels, spare channels and line framing
// assumes the bench places it beside the interface with the link clock running
module pgo_monitor
  import pgo_pkg::*;
(
  input wire logic                        serializer_clock_input,
  input wire logic                        srst,
  input wire logic [NUM_TX-1:0][CH_W-1:0] tx_ch
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAX_BEATS = 512;
  localparam int MIN_GAP   = 376;
  logic        lv;
  logic [11:0] len_r;
  logic [11:0] gap_r;

  assign lv = tx_ch[2][24];

  default clocking cb @(posedge serializer_clock_input);
  endclocking
  default disable iff (srst);

  // gap saturates so a long idle spell cannot wrap into a false short gap
  always_ff @(posedge serializer_clock_input) begin
    if (srst) begin
      len_r <= 12'h000;
      gap_r <= 12'h000;
    end else begin
      len_r <= lv ? len_r + 12'h001 : 12'h000;
      gap_r <= lv ? 12'h000 : ((gap_r == 12'hfff) ? gap_r : gap_r + 12'h001);
    end
  end

  dval_match_a: assert property (tx_ch[2][26] == lv)
    else $error("data valid differs from line valid");
  tx_align_a: assert property (tx_ch[0][26:24] == tx_ch[2][26:24] &&
                               tx_ch[1][26:24] == tx_ch[2][26:24])
    else $error("flag channels differ between transmitters");
  fval_unused_a: assert property (!tx_ch[0][25] && !tx_ch[1][25] && !tx_ch[2][25])
    else $error("frame valid channel driven");
  spare_quiet_a: assert property (tx_ch[2][23:15] == 9'h000 && !tx_ch[0][23] && !tx_ch[1][23])
    else $error("spare channel driven");
  line_min_a: assert property ($rose(lv) |-> lv [*8])
    else $error("line shorter than eight beats");
  line_gap_a: assert property ($fell(lv) |-> !lv [*8])
    else $error("line valid back too soon");
  line_max_a: assert property (lv |-> len_r < MAX_BEATS)
    else $error("line longer than a full sensor line");
  delay_min_a: assert property ($rose(lv) |-> gap_r >= MIN_GAP)
    else $error("line valid delay below the shortest base");

  line_seen_c: cover property ($rose(lv));
  full_line_c: cover property (lv && len_r == 12'h1ff);
  short_line_c: cover property ($fell(lv) && $past(len_r) == 12'h01f);
endmodule : pgo_monitor

// >>> pgo_pkg.sv
// constants, types and helpers shared by both ends of the 8-tap pixel link
// assumes the link clock is made by the bench and that both ends see the same copy of it
package pgo_pkg;
  localparam int TAPS      = 8;
  localparam int NUM_TX    = 3;
  localparam int CH_W      = 28;
  localparam int PX_W      = 12;
  localparam int LINK_W    = 8;
  localparam int GAIN_W    = 14;
  localparam int OFF_W     = 13;
  localparam int GAIN_FRAC = 12;
  localparam int BEAT_W    = 10;
  localparam int DLY_W     = 17;

  typedef logic [7:0][4:0] pgo_map_t;
  // per slot of a transmitter: channel of each pixel bit, bit 7 first
  localparam pgo_map_t MAP_SLOT0 = {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam pgo_map_t MAP_SLOT1 = {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07};
  localparam pgo_map_t MAP_SLOT2 = {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f};
  localparam logic [2:0][7:0][4:0] TAP_MAP = {MAP_SLOT2, MAP_SLOT1, MAP_SLOT0};
  localparam logic [4:0] LVAL_CH = 5'h18;
  localparam logic [4:0] FVAL_CH = 5'h19;
  localparam logic [4:0] DVAL_CH = 5'h1a;

  localparam logic [13:0] GAIN_MIN   = 14'h0aab;
  localparam logic [13:0] GAIN_MAX8  = 14'h3fff;
  localparam logic [13:0] GAIN_MAX10 = 14'h2000;
  localparam logic [13:0] GAIN_MAX12 = 14'h1800;
  localparam logic [13:0] GAIN_RST   = 14'h1000;
  localparam logic signed [12:0] OFF_MIN = 13'sh1001;
  localparam logic signed [12:0] OFF_MAX = 13'sh0fff;
  localparam logic signed [12:0] OFF_RST = 13'sh0000;
  localparam logic [11:0] PX_FULL = 12'hfff;
  localparam logic signed [4:0] DB_MIN = -5'sd3;
  localparam logic signed [4:0] DB_MAX = 5'sd12;

  localparam logic [1:0] DEPTH_8   = 2'h0;
  localparam logic [1:0] DEPTH_10  = 2'h1;
  localparam logic [1:0] DEPTH_12  = 2'h2;
  localparam logic [1:0] EXP_PROG  = 2'h0;
  localparam logic [1:0] EXP_EDGE  = 2'h1;
  localparam logic [1:0] EXP_LEVEL = 2'h2;

  localparam int N_4K = 4096;
  localparam int N_2K = 2048;

  localparam int CLK_SLOW_MHZ = 40;
  localparam int CLK_FAST_MHZ = 80;
  localparam int DLY_B40_NS   = 9400;
  localparam int DLY_B40B_NS  = 12850;
  localparam int DLY_B80_NS   = 12450;
  localparam int DLY_B80B_NS  = 14300;
  localparam int DLY_E40_NS   = 9750;
  localparam int DLY_E40B_NS  = 13200;
  localparam int DLY_E80_NS   = 12800;
  localparam int DLY_E80B_NS  = 14650;
  localparam logic [16:0] DLY_B40_CYC  = 17'(DLY_B40_NS * CLK_SLOW_MHZ / 1000);
  localparam logic [16:0] DLY_B40B_CYC = 17'(DLY_B40B_NS * CLK_SLOW_MHZ / 1000);
  localparam logic [16:0] DLY_B80_CYC  = 17'(DLY_B80_NS * CLK_FAST_MHZ / 1000);
  localparam logic [16:0] DLY_B80B_CYC = 17'(DLY_B80B_NS * CLK_FAST_MHZ / 1000);
  localparam logic [16:0] DLY_E40_CYC  = 17'(DLY_E40_NS * CLK_SLOW_MHZ / 1000);
  localparam logic [16:0] DLY_E40B_CYC = 17'(DLY_E40B_NS * CLK_SLOW_MHZ / 1000);
  localparam logic [16:0] DLY_E80_CYC  = 17'(DLY_E80_NS * CLK_FAST_MHZ / 1000);
  localparam logic [16:0] DLY_E80B_CYC = 17'(DLY_E80B_NS * CLK_FAST_MHZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_LINE = 3'b100
  } pgo_state_e;

  typedef struct packed {
    logic [13:0]        gain;
    logic signed [12:0] offset;
    logic [1:0]         depth;
    logic [1:0]         exp_mode;
    logic               single_line;
    logic               fast_clk;
    logic               binning;
    logic               sensor_4k;
    logic               roi_en;
    logic [12:0]        roi_len;
    logic [15:0]        exp_cyc;
  } pgo_cfg_s;

  localparam pgo_cfg_s CFG_RST = '{gain: GAIN_RST, offset: OFF_RST, depth: DEPTH_8,
                                   exp_mode: EXP_PROG, sensor_4k: 1'b1, default: '0};

  // integer setting nearest 4096 * 10^(db/20), whole decibels only
  function automatic logic [13:0] pgo_gain_from_db(input logic signed [4:0] db);
    case (db)
      -5'sd3:  return 14'h0b54;
      -5'sd2:  return 14'h0cb6;
      -5'sd1:  return 14'h0e43;
      5'sd0:   return 14'h1000;
      5'sd1:   return 14'h11f4;
      5'sd2:   return 14'h1425;
      5'sd3:   return 14'h169a;
      5'sd4:   return 14'h195c;
      5'sd5:   return 14'h1c74;
      5'sd6:   return 14'h1fed;
      5'sd7:   return 14'h23d2;
      5'sd8:   return 14'h2831;
      5'sd9:   return 14'h2d18;
      5'sd10:  return 14'h3299;
      5'sd11:  return 14'h38c5;
      5'sd12:  return 14'h3fb2;
      default: return GAIN_RST;
    endcase
  endfunction : pgo_gain_from_db
endpackage : pgo_pkg

// >>> pgo_rx.sv
// frame grabber end: rebuilds eight 8-bit taps from the three transmitter words
// everything runs on the recovered pixel clock; user outputs are in that domain
module pgo_rx
  import pgo_pkg::*;
(
  input  wire logic                      srst,
  pgo_if.rx                              link,
  output logic [TAPS-1:0][LINK_W-1:0]    px_taps,
  output logic                           px_valid,
  output logic                           px_line_start,
  output logic                           px_line_end,
  output logic [BEAT_W-1:0]              px_line_beats
);

  typedef struct packed {
    logic [1:0]                  rst_s;
    logic [TAPS-1:0][LINK_W-1:0] taps;
    logic                        valid;
    logic                        sol;
    logic                        eol;
    logic [BEAT_W-1:0]           cnt;
    logic [BEAT_W-1:0]           beats;
  } pgo_rxs_s;

  pgo_rxs_s r_r, r_nxt;
  logic     pclk;
  logic     lv;
  assign pclk = link.serializer_clock_input;

  // frame valid and spare channels are never looked at
  assign lv = link.tx_ch[2][LVAL_CH] & link.tx_ch[2][DVAL_CH];

  always_comb begin
    r_nxt       = r_r;
    r_nxt.rst_s = {r_r.rst_s[0], srst};
    r_nxt.valid = lv;
    r_nxt.sol   = lv & ~r_r.valid;
    r_nxt.eol   = ~lv & r_r.valid;
    if (lv) begin
      for (int t = 0; t < TAPS; t++) begin
        for (int b = 0; b < LINK_W; b++) begin
          r_nxt.taps[t][b] = link.tx_ch[t / 3][TAP_MAP[t % 3][b]];
        end
      end
      r_nxt.cnt = r_r.valid ? r_r.cnt + 1'b1 : BEAT_W'(1);
    end else if (r_r.valid) begin
      r_nxt.beats = r_r.cnt;
    end
    if (r_r.rst_s[1]) begin
      r_nxt       = '0;
      r_nxt.rst_s = {r_r.rst_s[0], srst};
    end
  end

  always_ff @(posedge pclk) begin
    r_r <= r_nxt;
  end

  assign px_taps       = r_r.taps;
  assign px_valid      = r_r.valid;
  assign px_line_start = r_r.sol;
  assign px_line_end   = r_r.eol;
  assign px_line_beats = r_r.beats;

endmodule : pgo_rx

// >>> pgo_tb_top.sv
// bench joining the camera end and the grabber end over the 8-tap link
// assumes both clocks come from here; the link clock runs through reset
module pgo_tb_top
  import pgo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, lclk, srst, cfg_we, line_start, cfg_busy, sensor_rd;
  logic [13:0] cfg_gain_raw;
  logic signed [4:0] cfg_gain_db;
  logic signed [12:0] cfg_off_raw, cfg_off_dn;
  logic cfg_gain_by_db, cfg_off_by_dn, cfg_single_line, cfg_fast_clk;
  logic cfg_binning, cfg_sensor_4k, cfg_roi_en;
  logic [1:0] cfg_depth, cfg_exp_mode;
  logic [12:0] cfg_roi_len;
  logic [15:0] cfg_exp_cyc;
  logic [TAPS-1:0][PX_W-1:0] sensor_px;
  logic [TAPS-1:0][LINK_W-1:0] px_taps;
  logic px_valid, px_line_start, px_line_end, lvp;
  logic [BEAT_W-1:0] px_line_beats;
  logic [9:0] sb;
  logic [7:0] g6, g7;
  int n_fail, tests_run, cg, co, cd, nb, dl, k, jt;
  int c6 [8] = '{0, 1, 2, 3, 4, 6, 27, 5};
  int c7 [8] = '{7, 8, 9, 12, 13, 14, 10, 11};
  int dtab [8] = '{376, 514, 996, 1144, 390, 528, 1024, 1172};

  pgo_if link ();
  assign link.serializer_clock_input = lclk;

  pgo_dev u_pgo_dev (.clk_sys(clk_sys), .srst(srst), .cfg_we(cfg_we),
    .cfg_gain_raw(cfg_gain_raw), .cfg_gain_db(cfg_gain_db), .cfg_gain_by_db(cfg_gain_by_db),
    .cfg_off_raw(cfg_off_raw), .cfg_off_dn(cfg_off_dn), .cfg_off_by_dn(cfg_off_by_dn),
    .cfg_depth(cfg_depth), .cfg_exp_mode(cfg_exp_mode), .cfg_single_line(cfg_single_line),
    .cfg_fast_clk(cfg_fast_clk), .cfg_binning(cfg_binning), .cfg_sensor_4k(cfg_sensor_4k),
    .cfg_roi_en(cfg_roi_en), .cfg_roi_len(cfg_roi_len), .cfg_exp_cyc(cfg_exp_cyc),
    .line_start(line_start), .cfg_busy(cfg_busy), .sensor_rd(sensor_rd),
    .sensor_px(sensor_px), .link(link));
  pgo_rx u_pgo_rx (.srst(srst), .link(link), .px_taps(px_taps), .px_valid(px_valid),
    .px_line_start(px_line_start), .px_line_end(px_line_end), .px_line_beats(px_line_beats));
  pgo_monitor u_pgo_monitor (.serializer_clock_input(link.serializer_clock_input),
    .srst(srst), .tx_ch(link.tx_ch));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    lclk = 1'b0;
    #13;
    forever #32 lclk = ~lclk;
  end

  // pixel p of a line carries p in its upper bits, so tap order shows in the output
  always @(posedge lclk) sb <= sensor_rd ? sb + 10'h001 : 10'h000;
  always_comb begin
    for (int t = 0; t < TAPS; t++) begin
      sensor_px[t] = {8'(sb * 8 + t), 4'h0};
    end
  end

  function automatic logic [7:0] expv(input int p);
    int v;
    v = (((p % 256) * 16 * cg) >>> 12) + co;
    v = (v < 0) ? 0 : ((v > 4095) ? 4095 : v);
    return 8'(v >> ((cd == 0) ? 4 : ((cd == 1) ? 2 : 0)));
  endfunction : expv

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge lclk) begin
    if (link.tx_ch[2][24] === 1'b1) begin
      jt = lvp ? jt + 1 : 0;
      for (int b = 0; b < 8; b++) begin
        g6[b] = link.tx_ch[2][c6[b]];
        g7[b] = link.tx_ch[2][c7[b]];
      end
      check(g6 === expv(jt * 8 + 6), "tap six wire bits");
      check(g7 === expv(jt * 8 + 7), "tap seven wire bits");
    end
    lvp = (link.tx_ch[2][24] === 1'b1);
    if (px_valid === 1'b1) begin
      k = (px_line_start === 1'b1) ? 0 : k + 1;
      for (int t = 0; t < TAPS; t++) begin
        check(px_taps[t] === expv(k * 8 + t), "tap value");
      end
    end
    if (px_line_end === 1'b1) begin
      check(px_line_beats === 10'(nb), "beats per line");
    end
  end

  task automatic cfg(input int g, gd, gb, o, od, ob, dep, em, sl, fc, bn, k4, rl, ex);
    int n;
    int mx;
    n = 0;
    @(posedge clk_sys);
    cfg_gain_raw <= 14'(g);
    cfg_gain_db <= 5'(gd);
    cfg_gain_by_db <= gb[0];
    cfg_off_raw <= 13'(o);
    cfg_off_dn <= 13'(od);
    cfg_off_by_dn <= ob[0];
    cfg_depth <= 2'(dep);
    cfg_exp_mode <= 2'(em);
    cfg_single_line <= sl[0];
    cfg_fast_clk <= fc[0];
    cfg_binning <= bn[0];
    cfg_sensor_4k <= k4[0];
    cfg_roi_en <= (rl != 0);
    cfg_roi_len <= 13'(rl);
    cfg_exp_cyc <= 16'(ex);
    cfg_we <= 1'b1;
    @(posedge clk_sys);
    cfg_we <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cfg_busy === 1'b1 && n < 300);
    check(n < 300, "config not taken");
    cd = dep;
    cg = (gb != 0) ? $rtoi(4096.0 * 10.0 ** (gd / 20.0) + 0.5) : g;
    mx = (dep == 0) ? 16383 : ((dep == 1) ? 8192 : 6144);
    cg = (cg < 2731) ? 2731 : ((cg > mx) ? mx : cg);
    co = (ob != 0) ? od * ((dep == 0) ? 16 : ((dep == 1) ? 4 : 1)) : o;
    co = (co < -4095) ? -4095 : ((co > 4095) ? 4095 : co);
    nb = (rl != 0) ? rl / 8 : ((k4 != 0) ? 4096 : 2048) >> (bn + 3);
    dl = dtab[{em == 1 && sl == 1, fc[0], bn[0]}] + ((em == 0) ? ex : 0);
  endtask : cfg

  task automatic run_line();
    int n;
    n = 0;
    @(posedge clk_sys);
    line_start <= 1'b1;
    @(posedge clk_sys);
    line_start <= 1'b0;
    while (link.tx_ch[2][24] !== 1'b1 && n < 3000) begin
      @(posedge lclk);
      n++;
    end
    check(n >= dl + 2 && n <= dl + 9, "line valid delay");
    n = 0;
    while (px_line_end !== 1'b1 && n < 5000) begin
      @(posedge lclk);
      n++;
    end
    check(n < 5000, "line never ended");
    @(posedge lclk);
  endtask : run_line

  task automatic t_reset();
    cg = 4096;
    co = 0;
    cd = 0;
    nb = 512;
    dl = 376;
    run_line();
  endtask : t_reset

  task automatic t_modes();
    int tb [6][5] = '{'{0, 0, 0, 0, 50}, '{1, 1, 0, 0, 0}, '{1, 0, 1, 0, 0},
                      '{2, 0, 0, 1, 0}, '{1, 1, 1, 1, 0}, '{0, 0, 1, 1, 20}};
    for (int i = 0; i < 6; i++) begin
      cfg(4096, 0, 0, 0, 0, 0, 0, tb[i][0], tb[i][1], tb[i][2], tb[i][3],
          int'(i != 3), (i == 3) ? 0 : 256, tb[i][4]);
      run_line();
    end
  endtask : t_modes

  task automatic t_gain();
    int tb [3][4] = '{'{8000, 0, 0, 2}, '{0, 6, 1, 1}, '{100, 0, 0, 0}};
    for (int i = 0; i < 3; i++) begin
      cfg(tb[i][0], tb[i][1], tb[i][2], 0, 0, 0, tb[i][3], 0, 0, 0, 0, 1, 256, 0);
      run_line();
    end
  endtask : t_gain

  task automatic t_offset();
    int tb [4][4] = '{'{0, -3, 1, 0}, '{7, 0, 0, 1}, '{1, 0, 0, 2}, '{-4096, 0, 0, 2}};
    for (int i = 0; i < 4; i++) begin
      cfg(4096, 0, 0, tb[i][0], tb[i][1], tb[i][2], tb[i][3], 0, 0, 0, 0, 1, 256, 0);
      run_line();
    end
  endtask : t_offset

  initial begin
    repeat (99000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end

  initial begin
    {srst, cfg_we, line_start, cfg_gain_by_db, cfg_off_by_dn, cfg_single_line} = 6'h21;
    {cfg_fast_clk, cfg_binning, cfg_sensor_4k, cfg_roi_en, cfg_depth, cfg_exp_mode} = 8'h20;
    {cfg_gain_raw, cfg_gain_db, cfg_off_raw, cfg_off_dn} = '0;
    {cfg_roi_len, cfg_exp_cyc} = '0;
    {n_fail, tests_run, k, jt, lvp} = '0;
    // the link side needs its own clock edges inside reset
    repeat (3) @(posedge lclk);
    @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge lclk);
    t_reset();
    t_modes();
    t_gain();
    t_offset();
    conclude();
  end
endmodule : pgo_tb_top
